// file: hdl/cas_pkg.sv
// Constants, types and register map of the compare/add/subtract unit.
// Assumes a 32-bit APB master on the same clock as the unit.
package cas_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ACC = 12'h004;
    localparam logic [11:0] ADDR_STACK = 12'h008;
    localparam logic [11:0] ADDR_OPND = 12'h00c;
    localparam logic [11:0] ADDR_STAT = 12'h010;
    // Control register fields
    localparam int OP_LSB = 0;
    localparam int OP_MSB = 3;
    localparam int PTR_SEL_BIT = 4;
    localparam int PTR_BAD_BIT = 5;
    localparam int BUSY_BIT = 8;
    localparam int FLAGS_W = 14;
    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // BCD digit arithmetic
    localparam int DIGITS = 8;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ADD_FIX = 4'h6;
    localparam logic [3:0] BCD_SUB_FIX = 4'ha;
    // Single precision layout
    localparam int SIGN_BIT = 31;
    localparam logic [7:0] EXP_MAX = 8'hff;
    localparam logic [8:0] EXP_TOP = 9'h0fe;
    localparam logic [8:0] EXP_ONE = 9'h001;
    localparam logic [7:0] SHIFT_MAX = 8'h18;
    localparam logic [31:0] KEY_ZERO = 32'h8000_0000;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_STACK_COMPARE = 4'h1,
        OP_REAL_COMPARE = 4'h2,
        OP_BCD_ADD_16 = 4'h3,
        OP_BCD_ADD_32 = 4'h4,
        OP_BCD_SUBTRACT_16 = 4'h5,
        OP_BCD_SUBTRACT_32 = 4'h6,
        OP_REAL_ADD = 4'h7,
        OP_REAL_SUBTRACT = 4'h8
    } cas_op_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NORM = 2'b10
    } cas_state_e;
    typedef struct packed {
        logic less_than_flag;
        logic equal_flag;
        logic greater_than_flag;
        logic zero_flag;
        logic negative_flag;
        logic carry16_flag;
        logic carry32_flag;
        logic borrow16_flag;
        logic borrow32_flag;
        logic invalid_pointer_flag;
        logic invalid_real_flag;
        logic sign_error_flag;
        logic underflow_flag;
        logic non_bcd_flag;
    } cas_flags_s;
endpackage

// file: hdl/cas_alu.sv
// Accumulator compare, BCD add/subtract and real add/subtract unit.
// Assumes an APB master on pclk; ce low freezes every flip-flop.
//
// Notes on behaviour
// (RULE_01) Stack compare sets flags, accumulator untouched
// (RULE_02) Greater flag when accumulator exceeds operand
// (RULE_03) Less flag when accumulator below stack
// (RULE_04) Equal flag when both values match
// (RULE_05) Flags hold until an op rewrites them
// (RULE_06) Real compare against two-word memory real
// (RULE_07) Invalid pointer flag for bad pointer operand
// (RULE_08) Four-digit BCD add into accumulator
// (RULE_09) Carry16 on 16-bit add carry out
// (RULE_10) Carry32 on 32-bit add carry out
// (RULE_11) Zero flag when result is zero
// (RULE_12) Negative flag when result is negative
// (RULE_13) Non-BCD flag on bad operand digit
// (RULE_14) Eight-digit BCD add into accumulator
// (RULE_15) Real add/subtract on IEEE operands
// (RULE_16) Invalid real flag for non-float accumulator
// (RULE_17) Sign error flag on wrong result sign
// (RULE_18) Underflow flag on float underflow
// (RULE_19) Four-digit BCD subtract from accumulator
// (RULE_20) Borrow16 on 16-bit subtract borrow
// (RULE_21) Borrow32 on 32-bit subtract borrow
// (RULE_22) Eight-digit BCD subtract from accumulator
// (RULE_23) Compare sets exactly one of three flags
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cas_alu (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output var cas_pkg::cas_flags_s status_flags,
    output logic busy
);
    cas_pkg::cas_state_e state_reg;
    cas_pkg::cas_op_e op_reg;
    cas_pkg::cas_flags_s flags_reg;
    logic [31:0] acc_reg, stack_reg, opnd_reg, prdata_reg, rd_mux;
    logic cap_reg, err_reg, ptr_sel_reg, ptr_bad_reg, hit, bad;
    logic xfer, wr, start, op_ok, is_real, is_bcd, is_sub, is16;
    logic [24:0] fsum_reg;
    logic [8:0] fexp_reg;
    logic fsign_reg;

    ////////////////////////////////////////////////////////////////
    // APB slave: capture in setup, answer in access (zero wait)
    assign xfer = ce & psel & penable & cap_reg;
    assign pready = xfer;
    assign pslverr = xfer & err_reg;
    assign prdata = prdata_reg;
    assign wr = xfer & pwrite & ~err_reg;
    assign busy = (state_reg != cas_pkg::ST_IDLE);
    assign status_flags = flags_reg;
    assign op_ok = (pwdata[cas_pkg::OP_MSB:cas_pkg::OP_LSB] != cas_pkg::OP_NOP)
        && (pwdata[cas_pkg::OP_MSB:cas_pkg::OP_LSB] <= cas_pkg::OP_REAL_SUBTRACT);
    assign start = wr && (paddr == cas_pkg::ADDR_CTRL) && op_ok;

    // Read mux; writes while busy are refused so the op sees fixed inputs
    always_comb begin
        rd_mux = cas_pkg::WORD_RST;
        hit = 1'b1;
        case (paddr)
            cas_pkg::ADDR_CTRL: begin
                rd_mux[cas_pkg::OP_MSB:cas_pkg::OP_LSB] = op_reg;
                rd_mux[cas_pkg::PTR_SEL_BIT] = ptr_sel_reg;
                rd_mux[cas_pkg::PTR_BAD_BIT] = ptr_bad_reg;
                rd_mux[cas_pkg::BUSY_BIT] = busy;
            end
            cas_pkg::ADDR_ACC: rd_mux = acc_reg;
            cas_pkg::ADDR_STACK: rd_mux = stack_reg;
            cas_pkg::ADDR_OPND: rd_mux = opnd_reg;
            cas_pkg::ADDR_STAT: rd_mux[cas_pkg::FLAGS_W-1:0] = flags_reg;
            default: hit = 1'b0;
        endcase
        bad = ~hit | (pwrite & ((paddr == cas_pkg::ADDR_STAT) | busy));
    end

    // Capture read data and error once per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_reg <= 1'b0;
            err_reg <= 1'b0;
            prdata_reg <= cas_pkg::WORD_RST;
        end else if (ce) begin
            if (xfer) begin
                cap_reg <= 1'b0;
            end else if (psel && !cap_reg) begin
                cap_reg <= 1'b1;
                err_reg <= bad;
                prdata_reg <= pwrite ? cas_pkg::WORD_RST : rd_mux;
            end
        end
    end

    // Operand and control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_reg <= cas_pkg::WORD_RST;
            opnd_reg <= cas_pkg::WORD_RST;
            ptr_sel_reg <= 1'b0;
            ptr_bad_reg <= 1'b0;
            op_reg <= cas_pkg::OP_NOP;
        end else if (ce && wr) begin
            case (paddr)
                cas_pkg::ADDR_STACK: stack_reg <= pwdata;
                cas_pkg::ADDR_OPND: opnd_reg <= pwdata;
                cas_pkg::ADDR_CTRL: begin
                    ptr_sel_reg <= pwdata[cas_pkg::PTR_SEL_BIT];
                    ptr_bad_reg <= pwdata[cas_pkg::PTR_BAD_BIT];
                    if (op_ok) begin
                        op_reg <= cas_pkg::cas_op_e'(pwdata[cas_pkg::OP_MSB:cas_pkg::OP_LSB]);
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Operation decode
    assign is_real = (op_reg == cas_pkg::OP_REAL_ADD) || (op_reg == cas_pkg::OP_REAL_SUBTRACT);
    assign is_sub = (op_reg == cas_pkg::OP_BCD_SUBTRACT_16)
        || (op_reg == cas_pkg::OP_BCD_SUBTRACT_32);
    assign is16 = (op_reg == cas_pkg::OP_BCD_ADD_16) || (op_reg == cas_pkg::OP_BCD_SUBTRACT_16);
    assign is_bcd = is_sub || is16 || (op_reg == cas_pkg::OP_BCD_ADD_32);

    // BCD digit chain; 16-bit forms use the low word of each operand
    logic [31:0] bcd_a, bcd_b, bcd_res, bcd_acc;
    logic [cas_pkg::DIGITS:0] bc;
    logic [cas_pkg::DIGITS-1:0] dig_bad;
    assign bcd_a = is16 ? {16'h0000, acc_reg[15:0]} : acc_reg;
    assign bcd_b = is16 ? {16'h0000, opnd_reg[15:0]} : opnd_reg;
    assign bc[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < cas_pkg::DIGITS; gi = gi + 1) begin : g_digit
            logic [3:0] da, db;
            logic [4:0] raw;
            assign da = bcd_a[4*gi +: 4];
            assign db = bcd_b[4*gi +: 4];
            // (RULE_08) digit add or subtract
            assign raw = is_sub ? ({1'b0, da} - {1'b0, db} - {4'h0, bc[gi]})
                : ({1'b0, da} + {1'b0, db} + {4'h0, bc[gi]});
            assign bc[gi+1] = is_sub ? raw[4] : (raw > {1'b0, cas_pkg::BCD_NINE});
            assign bcd_res[4*gi +: 4] = bc[gi+1]
                ? raw[3:0] + (is_sub ? cas_pkg::BCD_SUB_FIX : cas_pkg::BCD_ADD_FIX)
                : raw[3:0];
            // (RULE_13) digit range check
            assign dig_bad[gi] = (da > cas_pkg::BCD_NINE) | (db > cas_pkg::BCD_NINE);
        end
    endgenerate
    // (RULE_19) 16-bit forms leave the upper word clear
    assign bcd_acc = is16 ? {16'h0000, bcd_res[15:0]} : bcd_res;

    ////////////////////////////////////////////////////////////////
    // Real operand checks and ordering keys for compare
    function automatic logic [31:0] cas_key(input logic [31:0] v);
        if (v[30:0] == 31'h0000_0000) begin
            cas_key = cas_pkg::KEY_ZERO;
        end else begin
            cas_key = v[cas_pkg::SIGN_BIT] ? ~v : {1'b1, v[30:0]};
        end
    endfunction
    logic acc_inv, opnd_inv, ptr_inv;
    logic [31:0] key_a, key_b, cmp_a, cmp_b;
    assign acc_inv = (acc_reg[30:23] == cas_pkg::EXP_MAX);
    assign opnd_inv = (opnd_reg[30:23] == cas_pkg::EXP_MAX);
    assign ptr_inv = ptr_sel_reg & ptr_bad_reg;
    assign key_a = cas_key(acc_reg);
    assign key_b = cas_key(opnd_reg);
    // (RULE_06) real compare orders by key, stack compare as unsigned
    assign cmp_a = (op_reg == cas_pkg::OP_REAL_COMPARE) ? key_a : acc_reg;
    assign cmp_b = (op_reg == cas_pkg::OP_REAL_COMPARE) ? key_b : stack_reg;

    // Real add alignment; subnormal inputs count as zero
    logic [7:0] ea, eb, e1, ediff;
    logic [23:0] ma, mb, m1, m2;
    logic sa, sb, s1, a_big;
    logic [24:0] align_sum;
    always_comb begin
        ea = acc_reg[30:23];
        eb = opnd_reg[30:23];
        ma = (ea == 8'h00) ? 24'h00_0000 : {1'b1, acc_reg[22:0]};
        mb = (eb == 8'h00) ? 24'h00_0000 : {1'b1, opnd_reg[22:0]};
        sa = acc_reg[cas_pkg::SIGN_BIT];
        // (RULE_15) subtract flips the operand sign
        sb = opnd_reg[cas_pkg::SIGN_BIT] ^ (op_reg == cas_pkg::OP_REAL_SUBTRACT);
        a_big = {ea, ma} >= {eb, mb};
        e1 = a_big ? ea : eb;
        m1 = a_big ? ma : mb;
        s1 = a_big ? sa : sb;
        ediff = a_big ? (ea - eb) : (eb - ea);
        m2 = (ediff > cas_pkg::SHIFT_MAX) ? 24'h00_0000 : ((a_big ? mb : ma) >> ediff);
        align_sum = (sa == sb) ? ({1'b0, m1} + {1'b0, m2}) : ({1'b0, m1} - {1'b0, m2});
    end

    // Normalise step: one bit per cycle; ends on zero, range or hidden bit
    logic n_done, n_uf, n_ovf;
    logic [31:0] n_acc;
    always_comb begin
        n_done = 1'b0;
        n_uf = 1'b0;
        n_ovf = 1'b0;
        n_acc = {fsign_reg, fexp_reg[7:0], fsum_reg[22:0]};
        if (fsum_reg == 25'h000_0000) begin
            n_done = 1'b1;
            n_acc = cas_pkg::WORD_RST;
        end else if (fsum_reg[24]) begin
            if (fexp_reg >= cas_pkg::EXP_TOP) begin
                n_done = 1'b1;
                n_ovf = 1'b1;
                n_acc = {fsign_reg, cas_pkg::EXP_MAX, 23'h00_0000};
            end
        end else if (!fsum_reg[23]) begin
            if (fexp_reg <= cas_pkg::EXP_ONE) begin
                n_done = 1'b1;
                n_uf = 1'b1;
                n_acc = cas_pkg::WORD_RST;
            end
        end else begin
            n_done = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer: real ops with valid inputs go through normalisation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= cas_pkg::ST_IDLE;
        end else if (ce) begin
            case (state_reg)
                cas_pkg::ST_IDLE: if (start) state_reg <= cas_pkg::ST_EXEC;
                cas_pkg::ST_EXEC: begin
                    state_reg <= (is_real && !acc_inv && !opnd_inv)
                        ? cas_pkg::ST_NORM : cas_pkg::ST_IDLE;
                end
                cas_pkg::ST_NORM: if (n_done) state_reg <= cas_pkg::ST_IDLE;
                default: state_reg <= cas_pkg::ST_IDLE;
            endcase
        end
    end

    // Working mantissa and exponent of the real adder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsum_reg <= 25'h000_0000;
            fexp_reg <= 9'h000;
            fsign_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == cas_pkg::ST_EXEC) begin
                fsum_reg <= align_sum;
                fexp_reg <= {1'b0, e1};
                fsign_reg <= s1;
            end else if (state_reg == cas_pkg::ST_NORM && !n_done) begin
                fsum_reg <= fsum_reg[24] ? {1'b0, fsum_reg[24:1]} : {fsum_reg[23:0], 1'b0};
                fexp_reg <= fsum_reg[24] ? fexp_reg + 9'h001 : fexp_reg - 9'h001;
            end
        end
    end

    // (RULE_01) Accumulator: software writes when idle, results when busy; compares leave it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= cas_pkg::WORD_RST;
        end else if (ce) begin
            if (wr && paddr == cas_pkg::ADDR_ACC) begin
                acc_reg <= pwdata;
            end else if (state_reg == cas_pkg::ST_EXEC && is_bcd) begin
                // (RULE_14) (RULE_22) BCD sum or difference lands in accumulator
                acc_reg <= bcd_acc;
            end else if (state_reg == cas_pkg::ST_NORM && n_done) begin
                // (RULE_15) packed real result
                acc_reg <= n_acc;
            end
        end
    end

    // (RULE_05) Flags: each op rewrites only its own group, others hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else if (ce) begin
            if (state_reg == cas_pkg::ST_EXEC) begin
                if (op_reg == cas_pkg::OP_STACK_COMPARE || op_reg == cas_pkg::OP_REAL_COMPARE) begin
                    // (RULE_23) exactly one compare flag
                    // (RULE_03) less than operand
                    flags_reg.less_than_flag <= cmp_a < cmp_b;
                    // (RULE_04) equal to operand
                    flags_reg.equal_flag <= cmp_a == cmp_b;
                    // (RULE_02) greater than operand
                    flags_reg.greater_than_flag <= cmp_a > cmp_b;
                end
                if (op_reg != cas_pkg::OP_STACK_COMPARE) begin
                    // (RULE_07) pointer operand check
                    flags_reg.invalid_pointer_flag <= ptr_inv;
                end
                if (is_real || op_reg == cas_pkg::OP_REAL_COMPARE) begin
                    // (RULE_16) non-float accumulator or operand
                    flags_reg.invalid_real_flag <= acc_inv | opnd_inv;
                end
                if (is_bcd) begin
                    // (RULE_11) zero and negative follow the new accumulator
                    flags_reg.zero_flag <= bcd_acc == cas_pkg::WORD_RST;
                    flags_reg.negative_flag <= bcd_acc[cas_pkg::SIGN_BIT];
                    flags_reg.non_bcd_flag <= |dig_bad;
                    // (RULE_09) (RULE_10) carry out of digit four or eight
                    flags_reg.carry16_flag <= !is_sub && is16 && bc[4];
                    flags_reg.carry32_flag <= !is_sub && !is16 && bc[8];
                    // (RULE_20) (RULE_21) borrow out of digit four or eight
                    flags_reg.borrow16_flag <= is_sub && is16 && bc[4];
                    flags_reg.borrow32_flag <= is_sub && !is16 && bc[8];
                end
            end else if (state_reg == cas_pkg::ST_NORM && n_done) begin
                // (RULE_12) real zero and sign, (RULE_18) underflow
                flags_reg.zero_flag <= n_acc[30:0] == 31'h0000_0000;
                flags_reg.negative_flag <= n_acc[cas_pkg::SIGN_BIT];
                flags_reg.underflow_flag <= n_uf;
                // (RULE_17) sign error marks range overflow; result saturates to infinity
                flags_reg.sign_error_flag <= n_ovf;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    logic exec;
    assign exec = ce && state_reg == cas_pkg::ST_EXEC;

    a_cmp_onehot: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
        (exec && (op_reg == cas_pkg::OP_STACK_COMPARE || op_reg == cas_pkg::OP_REAL_COMPARE))
        |=> $onehot({flags_reg.less_than_flag, flags_reg.equal_flag,
        flags_reg.greater_than_flag}))
        else $error("compare flags not one-hot");

    a_stack_acc_keep: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        (exec && op_reg == cas_pkg::OP_STACK_COMPARE) |=> $stable(acc_reg) && !busy)
        else $error("stack compare changed accumulator");

    a_gt_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        (exec && op_reg == cas_pkg::OP_STACK_COMPARE)
        |=> flags_reg.greater_than_flag == ($past(acc_reg) > $past(stack_reg)))
        else $error("greater flag wrong");

    a_lt_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        (exec && op_reg == cas_pkg::OP_STACK_COMPARE && acc_reg < stack_reg)
        |=> flags_reg.less_than_flag && !flags_reg.greater_than_flag)
        else $error("less flag wrong");

    a_eq_real: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        (exec && op_reg == cas_pkg::OP_REAL_COMPARE && acc_reg == opnd_reg)
        |=> flags_reg.equal_flag)
        else $error("equal flag missed");

    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        (exec && is_bcd) |=> $stable({flags_reg.less_than_flag, flags_reg.equal_flag,
        flags_reg.greater_than_flag, flags_reg.underflow_flag}))
        else $error("unrelated flag overwritten");

    a_ptr_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        (exec && is_bcd && ptr_sel_reg && ptr_bad_reg) |=> flags_reg.invalid_pointer_flag)
        else $error("invalid pointer flag missed");

    a_carry16_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        (exec && op_reg == cas_pkg::OP_BCD_ADD_16 && acc_reg[15:0] == 16'h9999
        && opnd_reg[15:0] == 16'h0001)
        |=> flags_reg.carry16_flag && flags_reg.zero_flag && acc_reg == 32'h0000_0000)
        else $error("16-bit BCD carry wrong");

    a_borrow32_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
        (exec && op_reg == cas_pkg::OP_BCD_SUBTRACT_32 && acc_reg == 32'h0000_0000
        && opnd_reg == 32'h0000_0001)
        |=> flags_reg.borrow32_flag && acc_reg == 32'h9999_9999 && flags_reg.negative_flag)
        else $error("32-bit BCD borrow wrong");

    a_nonbcd_digit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        (exec && is_bcd && acc_reg[3:0] > 4'h9) |=> flags_reg.non_bcd_flag)
        else $error("non-BCD flag missed");
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the compare/add/subtract unit, driven over APB.
// Assumes cas_alu and cas_pkg as delivered; ce is held high for the whole run.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Flag masks in status order, less-than at the top
    localparam logic [13:0] LT = 14'h2000, EQ = 14'h1000, GT = 14'h0800, ZF = 14'h0400;
    localparam logic [13:0] NG = 14'h0200, C16 = 14'h0100, C32 = 14'h0080, B16 = 14'h0040;
    localparam logic [13:0] B32 = 14'h0020, IP = 14'h0010, IR = 14'h0008, SE = 14'h0004;
    localparam logic [13:0] UF = 14'h0002, NB = 14'h0001, CMP = 14'h3800;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    cas_pkg::cas_flags_s status_flags;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int n_tests = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns
    always #2 pclk = ~pclk;

    cas_alu i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_flags(status_flags), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict; also the landing place of every expired wait
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer, entered at an edge; an idle edge follows so the next
    // call never reassigns psel in the same time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready, data and error are taken at the completing edge itself
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Start an operation and wait, bounded, until busy drops
    task automatic op(input logic [31:0] ctrl);
        int i;
        apb(1'b1, cas_pkg::ADDR_CTRL, ctrl);
        for (i = 0; i < 100; i++) begin
            #1;
            if (busy === 1'b0) break;
            @(posedge pclk);
        end
        if (i == 100) begin
            n_fail++;
            end_of_test();
        end
        @(posedge pclk);
    endtask

    // Load accumulator and operand, run, then check accumulator and masked flags
    task automatic run(input logic [31:0] ctrl, input logic [31:0] a, input logic [31:0] b,
        input int ca, input logic [31:0] ea, input logic [13:0] m, input logic [13:0] e);
        apb(1'b1, cas_pkg::ADDR_ACC, a);
        apb(1'b1, cas_pkg::ADDR_STACK, b);
        apb(1'b1, cas_pkg::ADDR_OPND, b);
        op(ctrl);
        apb(1'b0, cas_pkg::ADDR_ACC, 32'h0000_0000);
        if (ca != 0) begin
            chk(rd, ea, "accumulator");
        end
        chk({18'h0, status_flags & m}, {18'h0, e}, "flags");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset state and refused accesses
        apb(1'b0, cas_pkg::ADDR_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "status after reset");
        apb(1'b1, cas_pkg::ADDR_STAT, 32'h0000_0001);
        chk({31'h0, err}, 32'h0000_0001, "status write error");
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        // Stack compare: all three outcomes, accumulator untouched
        run(32'h1, 32'h5, 32'h7, 1, 32'h5, CMP, LT);
        run(32'h1, 32'h7, 32'h7, 1, 32'h7, CMP, EQ);
        run(32'h1, 32'h8000_0000, 32'h7, 1, 32'h8000_0000, CMP, GT);
        // BCD add leaves compare flags standing
        run(32'h3, 32'h1234, 32'h0001, 1, 32'h1235, CMP | C16 | ZF, GT);
        run(32'h3, 32'h9999, 32'h0001, 1, 32'h0, ZF | C16 | C32, ZF | C16);
        run(32'h4, 32'h9999_9999, 32'h1, 1, 32'h0, ZF | C32 | NB, ZF | C32);
        run(32'h4, 32'h1234_5678, 32'h1111_1111, 1, 32'h2345_6789, ZF | NG | C32, 14'h0);
        run(32'h3, 32'h000a, 32'h0001, 0, 32'h0, NB, NB);
        // BCD subtract
        run(32'h5, 32'h1234, 32'h0234, 1, 32'h1000, ZF | NG | B16, 14'h0);
        run(32'h5, 32'h0000, 32'h0001, 0, 32'h0, B16, B16);
        run(32'h6, 32'h0, 32'h1, 1, 32'h9999_9999, B32 | NG | ZF, B32 | NG);
        // Real compare, signed zeros equal, pointer checks
        run(32'h2, 32'h40e0_0000, 32'h40c0_0000, 1, 32'h40e0_0000, CMP, GT);
        run(32'h2, 32'h40c0_0000, 32'h40e0_0000, 1, 32'h40c0_0000, CMP, LT);
        run(32'h2, 32'h8000_0000, 32'h0, 1, 32'h8000_0000, CMP, EQ);
        run(32'h32, 32'h40e0_0000, 32'h40c0_0000, 0, 32'h0, IP, IP);
        run(32'h12, 32'h40e0_0000, 32'h40c0_0000, 0, 32'h0, IP, 14'h0);
        run(32'h33, 32'h1, 32'h1, 1, 32'h2, IP | NB, IP);
        run(32'h2, 32'h40e0_0000, 32'h40e0_0000, 1, 32'h40e0_0000, CMP, EQ);
        // Real add and subtract with their error flags
        run(32'h7, 32'h3f80_0000, 32'h4000_0000, 1, 32'h4040_0000, 14'h040f, 14'h0);
        run(32'h8, 32'h3f80_0000, 32'h4040_0000, 1, 32'hc000_0000, NG | ZF, NG);
        run(32'h7, 32'h7f80_0000, 32'h3f80_0000, 1, 32'h7f80_0000, IR, IR);
        run(32'h8, 32'h00c0_0000, 32'h0080_0000, 1, 32'h0, UF | ZF, UF | ZF);
        run(32'h7, 32'h7f00_0000, 32'h7f00_0000, 1, 32'h7f80_0000, SE, SE);
        // Status register mirrors the last real add outcome
        apb(1'b0, cas_pkg::ADDR_STAT, 32'h0000_0000);
        chk(rd & 32'h0000_0007, 32'h0000_0004, "status word");
        end_of_test();
    end
endmodule
`default_nettype wire
